// ---- reply_map.svh ----
// What this block does
// - Reply output buffer holds 1024 characters for the controller.
// - Full reply buffer is a deadlock: discard replies, queue an error.
// - Deadlock also sets the query error bit of the event status.
// - Message-available status bit set while any reply waits.
// - Output ready flag in the response register while reply waits.
// - Read-status-byte command CFFF hex answers the current status byte.
// - Every error sets its bit in the event status register.
// - Every error also places an entry in the error queue while it has room.
// - Error queue holds at most 15 entries; new errors append.
// - Each error queue query removes one entry and replies with it; an empty queue replies 0, "No error".
// - Error reply is code, comma, then quoted message text.
// - A queued error replies with a negative code.
// - Message text of an error reply sits between double quotes.
// - Relay commands may queue; only a query reply proves them done.
// - Completion query reply waits until all relay operations finish.
// - 256-char input buffer; input ready flag low while it is full.
// - Clear command FFFF hex empties both buffers, ready again.
// - Filling the last queue place reports -350 queue overflow.
`ifndef REPLY_MAP_SVH
`define REPLY_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_WS_CMD 6'h00
`define OFS_WS_RESP 6'h04
`define OFS_RESPONSE 6'h08
`define OFS_IN_CHAR 6'h0c
`define OFS_IN_POP 6'h10
`define OFS_REPLY_PUSH 6'h14
`define OFS_REPLY_POP 6'h18
`define OFS_ERR_PUSH 6'h1c
`define OFS_QUERY 6'h20
`define OFS_ESR 6'h24
`define OFS_RELAY 6'h28
`define OFS_STB 6'h2c
// ****************************************
// Commands, bits and sizes
// ****************************************
`define WS_READ_STB 16'hcfff
`define WS_CLEAR 16'hffff
`define IN_AW 8
`define OUT_AW 10
`define EQ_DEPTH 4'hf
`define EQ_LAST 4'he
`define ESR_QUERY_ERR 3'h2
`define STB_MAV 3'h4
`define STB_EAV 3'h2
`define Q_ERR 0
`define Q_ESR 1
`define Q_OPC 2
`define RLY_QUEUED 0
`define RLY_DONE 1
`define CODE_OVERFLOW 10'h15e
`define CODE_DEADLOCK 10'h19a
`define OPC_VALUE 10'h001
`define DEC_100 10'h064
`define DEC_10 10'h00a
`define MSG_NONE 2'h0
`define MSG_OVERFLOW 2'h1
`define MSG_DEADLOCK 2'h2
`define MSG_COMMAND 2'h3
`define CH_MINUS 8'h2d
`define CH_COMMA 8'h2c
`define CH_QUOTE 8'h22
`define CH_LF 8'h0a
`define CH_ZERO 8'h30
`endif

// ---- reply_pkg.sv ----
package reply_pkg;
    // Reply formatter steps
    typedef enum logic [3:0] {
        F_IDLE = 4'h0,
        F_SIGN = 4'h1,
        F_D2 = 4'h2,
        F_D1 = 4'h3,
        F_D0 = 4'h4,
        F_COMMA = 4'h5,
        F_OQ = 4'h6,
        F_MSG = 4'h7,
        F_CQ = 4'h8,
        F_NL = 4'h9
    } fmt_state_type;
    // One queued error: magnitude of a negative code and message id
    typedef struct packed {
        logic [9:0] mag;
        logic [1:0] msg;
    } err_entry_type;
endpackage : reply_pkg

// ---- char_fifo.sv ----
`timescale 1ns/1ns
module char_fifo #(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic [7:0] data_i,
    input wire logic pop_i,
    // State
    output logic [7:0] data_o,
    output logic empty_o,
    output logic full_o
);
    localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    logic [7:0] mem [0:(1 << AW) - 1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    assign empty_o = (count == '0);
    assign full_o = (count == DEPTH);
    assign data_o = empty_o ? 8'h00 : mem[rd_ptr]; // No stale char shown
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;

    // Storage, no reset so it maps onto block RAM
    always_ff @(posedge ref_clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= data_i;
        end
    end

    // Pointers; clear drops everything at once
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clear_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : char_fifo

// ---- reply_buffer_error_queue.sv ----
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "reply_map.svh"
module reply_buffer_error_queue (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ****************************************
    // Declarations
    // ****************************************
    reply_pkg::fmt_state_type fstate;
    reply_pkg::err_entry_type eq_mem [0:`EQ_DEPTH - 1];
    reply_pkg::err_entry_type eq_head, new_err;
    logic rd_ack, wr_ok, rd_take, fmt_busy, in_empty, in_full, out_empty;
    logic out_full, out_push, out_pop, in_pop, ws_clear, esr_clr, eq_push;
    logic eq_pop, sw_err, q_err, q_esr, opc_wait, opc_fire, f_neg, f_text;
    logic fmt_emit, fmt_adv, msg_last;
    logic [7:0] in_data, out_data, out_char, stb, esr, esr_set;
    logic [7:0] relay_pending, fmt_char, msg_char;
    logic [3:0] eq_wr, eq_rd, eq_cnt, f_idx, hund, tens, ones;
    logic [15:0] ws_resp;
    logic [9:0] f_val;
    logic [1:0] f_msg;
    // Register select, used by every decode except the read data mux
    function automatic logic sel(input logic [5:0] addr,
                                 input logic [5:0] ofs);
        sel = ({addr[5:2], 2'b00} == ofs);
    endfunction : sel

    // Message text, right-justified, with its length
    function automatic logic [132:0] msg_text(input logic [1:0] m);
        case (m)
            `MSG_NONE: msg_text = {5'h08, 128'("No error")};
            `MSG_OVERFLOW: msg_text = {5'h0e, 128'("Queue overflow")};
            `MSG_DEADLOCK: msg_text = {5'h10, 128'("Query DEADLOCKED")};
            default: msg_text = {5'h0d, 128'("Command error")};
        endcase
    endfunction : msg_text

    // ****************************************
    // Bus handshake
    // ****************************************
    // Reads take two cycles so read data comes from a flop
    assign avs_waitrequest = avs_read ? !rd_ack :
        avs_write && (((sel(avs_address, `OFS_QUERY) ||
                        sel(avs_address, `OFS_REPLY_PUSH)) && fmt_busy) ||
                      (sel(avs_address, `OFS_ERR_PUSH) && out_full));

    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && !rd_ack;

    // Read acknowledge pulses high for one cycle per read
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= rd_take;
        end
    end

    // Status byte contents from buffer and queue state
    always_comb begin
        stb = 8'h00;
        stb[`STB_MAV] = !out_empty;
        stb[`STB_EAV] = (eq_cnt != 4'h0);
    end

    // Read data latched on the first read cycle; unmapped reads zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            case ({avs_address[5:2], 2'b00})
                `OFS_WS_RESP: avs_readdata <= {16'h0000, ws_resp};
                `OFS_RESPONSE: avs_readdata <= {28'h0000000, fmt_busy,
                    opc_wait, !in_full, !out_empty};
                `OFS_IN_POP: avs_readdata <= {23'h000000, !in_empty, in_data};
                `OFS_REPLY_POP: avs_readdata <= {23'h000000, !out_empty,
                    out_data};
                `OFS_ESR: avs_readdata <= {24'h000000, esr};
                `OFS_STB: avs_readdata <= {24'h000000, stb};
                `OFS_RELAY: avs_readdata <= {24'h000000, relay_pending};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Buffers
    // ****************************************
    assign in_pop = rd_take && sel(avs_address, `OFS_IN_POP);
    assign out_pop = rd_take && sel(avs_address, `OFS_REPLY_POP);
    assign ws_clear = wr_ok && sel(avs_address, `OFS_WS_CMD) &&
                      (avs_writedata[15:0] == `WS_CLEAR);

    // Command input; writes into a full buffer are dropped
    char_fifo #(.AW(`IN_AW)) in_buf (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clear_i(ws_clear),
        .push_i(wr_ok && sel(avs_address, `OFS_IN_CHAR)),
        .data_i(avs_writedata[7:0]),
        .pop_i(in_pop),
        .data_o(in_data),
        .empty_o(in_empty),
        .full_o(in_full)
    );

    // Reply output; full means deadlock and is dropped next edge
    char_fifo #(.AW(`OUT_AW)) out_buf (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .clear_i(ws_clear || out_full),
        .push_i(out_push),
        .data_i(out_char),
        .pop_i(out_pop),
        .data_o(out_data),
        .empty_o(out_empty),
        .full_o(out_full)
    );

    // Formatter owns the buffer while busy, software otherwise
    assign out_push = fmt_busy ? fmt_emit && !out_full
                               : wr_ok && sel(avs_address, `OFS_REPLY_PUSH);
    assign out_char = fmt_busy ? fmt_char : avs_writedata[7:0];

    // ****************************************
    // Word-serial answers
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ws_resp <= 16'h0000;
        end else if (wr_ok && sel(avs_address, `OFS_WS_CMD) &&
                     avs_writedata[15:0] == `WS_READ_STB) begin
            ws_resp <= {8'h00, stb};
        end
    end

    // ****************************************
    // Event status register
    // ****************************************
    assign sw_err = wr_ok && sel(avs_address, `OFS_ERR_PUSH);
    assign q_err = wr_ok && sel(avs_address, `OFS_QUERY) &&
                   avs_writedata[`Q_ERR];
    assign q_esr = wr_ok && sel(avs_address, `OFS_QUERY) &&
                   avs_writedata[`Q_ESR] && !avs_writedata[`Q_ERR];
    assign esr_clr = q_esr || (rd_take && sel(avs_address, `OFS_ESR));

    always_comb begin
        esr_set = 8'h00;
        if (sw_err) begin
            esr_set[avs_writedata[18:16]] = 1'b1;
        end
        if (out_full) begin
            esr_set[`ESR_QUERY_ERR] = 1'b1;
        end
    end

    // Reading clears; a bit set in the same cycle survives
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            esr <= 8'h00;
        end else begin
            esr <= (esr_clr ? 8'h00 : esr) | esr_set;
        end
    end

    // ****************************************
    // Error queue
    // ****************************************
    assign eq_push = sw_err || out_full;
    assign eq_pop = q_err && (eq_cnt != 4'h0);
    assign eq_head = eq_mem[eq_rd];

    // Entry to store; the last free place gets the overflow mark
    always_comb begin
        if (out_full) begin
            new_err = '{mag: `CODE_DEADLOCK, msg: `MSG_DEADLOCK};
        end else begin
            new_err = '{mag: avs_writedata[9:0], msg: `MSG_COMMAND};
        end
        if (eq_cnt == `EQ_LAST) begin
            new_err = '{mag: `CODE_OVERFLOW, msg: `MSG_OVERFLOW};
        end
    end

    // Circular store of 15 entries, oldest read first
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            eq_wr <= 4'h0;
            eq_rd <= 4'h0;
            eq_cnt <= 4'h0;
        end else begin
            if (eq_push && eq_cnt != `EQ_DEPTH) begin
                eq_wr <= (eq_wr == `EQ_LAST) ? 4'h0 : eq_wr + 4'h1;
            end
            if (eq_pop) begin
                eq_rd <= (eq_rd == `EQ_LAST) ? 4'h0 : eq_rd + 4'h1;
            end
            if (eq_push && eq_cnt != `EQ_DEPTH && !eq_pop) begin
                eq_cnt <= eq_cnt + 4'h1;
            end else if (eq_pop && !(eq_push && eq_cnt != `EQ_DEPTH)) begin
                eq_cnt <= eq_cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (eq_push && eq_cnt != `EQ_DEPTH) begin
            eq_mem[eq_wr] <= new_err;
        end
    end

    // ****************************************
    // Relay completion tracking
    // ****************************************
    // Relay logic reports each queued and each finished operation
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_pending <= 8'h00;
        end else if (wr_ok && sel(avs_address, `OFS_RELAY)) begin
            if (avs_writedata[`RLY_QUEUED] && !avs_writedata[`RLY_DONE] &&
                relay_pending != 8'hff) begin
                relay_pending <= relay_pending + 8'h01;
            end else if (avs_writedata[`RLY_DONE] &&
                         !avs_writedata[`RLY_QUEUED] &&
                         relay_pending != 8'h00) begin
                relay_pending <= relay_pending - 8'h01;
            end
        end
    end

    // Reply held back while any relay operation is outstanding
    assign opc_fire = opc_wait && (relay_pending == 8'h00) &&
                      !fmt_busy && !q_err && !q_esr;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            opc_wait <= 1'b0;
        end else if (ws_clear) begin
            opc_wait <= 1'b0;
        end else if (wr_ok && sel(avs_address, `OFS_QUERY) &&
                     avs_writedata[`Q_OPC]) begin
            opc_wait <= 1'b1;
        end else if (opc_fire) begin
            opc_wait <= 1'b0;
        end
    end

    // ****************************************
    // Reply formatter
    // ****************************************
    assign fmt_busy = (fstate != reply_pkg::F_IDLE);
    assign hund = 4'(f_val / `DEC_100);
    assign tens = 4'((f_val / `DEC_10) % `DEC_10);
    assign ones = 4'(f_val % `DEC_10);

    // Pick one message character by position
    always_comb begin
        logic [132:0] t;
        logic [4:0] len;
        t = msg_text(f_msg);
        len = t[132:128];
        msg_char = t[8 * (len - 5'h01 - {1'b0, f_idx}) +: 8];
        msg_last = ({1'b0, f_idx} == len - 5'h01);
    end

    // Character for each step; skipped steps emit nothing
    always_comb begin
        fmt_emit = 1'b1;
        fmt_char = `CH_ZERO;
        case (fstate)
            reply_pkg::F_SIGN: begin
                fmt_emit = f_neg;
                fmt_char = `CH_MINUS;
            end
            reply_pkg::F_D2: begin
                fmt_emit = (hund != 4'h0);
                fmt_char = `CH_ZERO + {4'h0, hund};
            end
            reply_pkg::F_D1: begin
                fmt_emit = (hund != 4'h0) || (tens != 4'h0);
                fmt_char = `CH_ZERO + {4'h0, tens};
            end
            reply_pkg::F_D0: fmt_char = `CH_ZERO + {4'h0, ones};
            reply_pkg::F_COMMA: fmt_char = `CH_COMMA;
            reply_pkg::F_OQ: fmt_char = `CH_QUOTE;
            reply_pkg::F_MSG: fmt_char = msg_char;
            reply_pkg::F_CQ: fmt_char = `CH_QUOTE;
            reply_pkg::F_NL: fmt_char = `CH_LF;
            default: fmt_emit = 1'b0;
        endcase
    end

    // Stalls while the buffer is full; the deadlock clear frees it
    assign fmt_adv = !fmt_emit || !out_full;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fstate <= reply_pkg::F_IDLE;
            f_neg <= 1'b0;
            f_text <= 1'b0;
            f_val <= 10'h000;
            f_msg <= `MSG_NONE;
            f_idx <= 4'h0;
        end else if (ws_clear) begin
            fstate <= reply_pkg::F_IDLE;
        end else begin
            case (fstate)
                reply_pkg::F_IDLE: begin
                    f_idx <= 4'h0;
                    if (q_err) begin
                        fstate <= reply_pkg::F_SIGN;
                        f_text <= 1'b1;
                        f_neg <= eq_pop;
                        f_val <= eq_pop ? eq_head.mag : 10'h000;
                        f_msg <= eq_pop ? eq_head.msg : `MSG_NONE;
                    end else if (q_esr) begin
                        fstate <= reply_pkg::F_SIGN;
                        f_text <= 1'b0;
                        f_neg <= 1'b0;
                        f_val <= {2'b00, esr};
                    end else if (opc_fire) begin
                        fstate <= reply_pkg::F_SIGN;
                        f_text <= 1'b0;
                        f_neg <= 1'b0;
                        f_val <= `OPC_VALUE;
                    end
                end
                reply_pkg::F_SIGN: if (fmt_adv) fstate <= reply_pkg::F_D2;
                reply_pkg::F_D2: if (fmt_adv) fstate <= reply_pkg::F_D1;
                reply_pkg::F_D1: if (fmt_adv) fstate <= reply_pkg::F_D0;
                reply_pkg::F_D0: begin
                    if (fmt_adv) begin
                        fstate <= f_text ? reply_pkg::F_COMMA
                                         : reply_pkg::F_NL;
                    end
                end
                reply_pkg::F_COMMA: if (fmt_adv) fstate <= reply_pkg::F_OQ;
                reply_pkg::F_OQ: if (fmt_adv) fstate <= reply_pkg::F_MSG;
                reply_pkg::F_MSG: begin
                    if (fmt_adv) begin
                        f_idx <= f_idx + 4'h1;
                        if (msg_last) begin
                            fstate <= reply_pkg::F_CQ;
                        end
                    end
                end
                reply_pkg::F_CQ: if (fmt_adv) fstate <= reply_pkg::F_NL;
                reply_pkg::F_NL: if (fmt_adv) fstate <= reply_pkg::F_IDLE;
                default: fstate <= reply_pkg::F_IDLE;
            endcase
        end
    end
endmodule : reply_buffer_error_queue

// ---- reply_checker.sv ----
`timescale 1ns/1ns
module reply_checker (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Bus signals
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // ****************************************
    // Port relations
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Read data is judged only at the edge the master takes it
    wire logic take = avs_read && !avs_waitrequest;
    chk_stb_bits: assert property (
        take && avs_address == 6'h2c |-> (avs_readdata & 32'hffffffeb) == 0)
        else $error("status byte carries stray bits");
    chk_resp_bits: assert property (
        take && avs_address == 6'h08 |-> avs_readdata[31:4] == 0)
        else $error("response word carries stray bits");
    chk_pop_width: assert property (
        take && avs_address == 6'h18 |-> avs_readdata[31:9] == 0 &&
            (avs_readdata[8] || avs_readdata[7:0] == 0))
        else $error("reply pop wider than one char");
    chk_esr_width: assert property (
        take && avs_address == 6'h24 |-> avs_readdata[31:8] == 0)
        else $error("event status wider than a byte");
    chk_relay_width: assert property (
        take && avs_address == 6'h28 |-> avs_readdata[31:8] == 0)
        else $error("relay count wider than a byte");
    chk_read_ack: assert property (
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered in one cycle");
    chk_err_stall: assert property (
        avs_write && avs_address == 6'h1c |-> ##[0:1] !avs_waitrequest)
        else $error("error push stalled too long");
    chk_relay_nowait: assert property (
        avs_write && avs_address == 6'h28 |-> !avs_waitrequest)
        else $error("relay write stalled");
endmodule : reply_checker
bind reply_buffer_error_queue reply_checker u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

// ---- ctl_model.sv ----
`timescale 1ns/1ns
module ctl_model (
    // Clock
    input wire logic ref_clk_i,
    // Slave answer
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Master request
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    // Idle bus from time zero
    initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
    // Held until waitrequest is seen low, released after that edge
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge ref_clk_i); while (avs_waitrequest);
        avs_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge ref_clk_i); while (avs_waitrequest);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask : rd
    // Word-serial status fetch and clear commands
    task automatic status_byte(output logic [31:0] v);
        wr(6'h00, 32'h0000cfff);
        rd(6'h04, v);
    endtask : status_byte
    task automatic clear;
        wr(6'h00, 32'h0000ffff);
    endtask : clear
endmodule : ctl_model

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    logic ref_clk_i;
    logic rst_i = 1'b1;
    logic [5:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, d;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    reply_buffer_error_queue dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    ctl_model ctl (.ref_clk_i(ref_clk_i), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata));
    // ****************************************
    // Clock, timeout and verdict
    // ****************************************
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic close_out;
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // Hang guard, well above the few thousand cycles needed
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            close_out();
        end
    end
    // ****************************************
    // Shared checks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdchk(input string n, input logic [5:0] a, e);
        ctl.rd(a, d);
        chk(n, {26'h0, e}, d);
    endtask : rdchk
    // Formatter runs one char a clock, so empty pops are retried
    task automatic query(input logic [31:0] q, input string s);
        int n;
        ctl.wr(6'h20, q);
        for (int i = 0; i < s.len(); i++) begin
            n = 0;
            do begin
                ctl.rd(6'h18, d);
                n++;
            end while (!d[8] && n < 64);
            chk("reply char", {23'h0, 1'b1, s[i]}, d);
        end
    endtask : query
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic avail_test;
        rdchk("idle stb", 6'h2c, 6'h00);
        ctl.wr(6'h14, 32'h41);
        rdchk("stb", 6'h2c, 6'h10);
        rdchk("response", 6'h08, 6'h03);
        ctl.status_byte(d);
        chk("status byte", 32'h10, d);
        ctl.rd(6'h18, d);
        chk("popped char", 32'h141, d);
        rdchk("pop empty", 6'h18, 6'h00);
        rdchk("drained", 6'h08, 6'h02);
    endtask : avail_test
    task automatic error_test;
        ctl.wr(6'h1c, 32'h00050066);
        rdchk("esr", 6'h24, 6'h20);
        rdchk("stb", 6'h2c, 6'h04);
        for (int i = 1; i <= 15; i++) ctl.wr(6'h1c, i);
        query(1, "-102,\"Command error\"\n");
        for (int i = 1; i <= 13; i++)
            query(1, $sformatf("-%0d,\"Command error\"\n", i));
        query(1, "-350,\"Queue overflow\"\n");
        query(1, "0,\"No error\"\n");
    endtask : error_test
    task automatic opc_test;
        ctl.wr(6'h28, 1);
        ctl.wr(6'h28, 1);
        ctl.wr(6'h20, 4);
        repeat (20) @(posedge ref_clk_i);
        rdchk("held reply", 6'h18, 6'h00);
        chk("held valid", 0, d[8]);
        rdchk("opc pending", 6'h08, 6'h06);
        ctl.wr(6'h28, 2);
        ctl.wr(6'h28, 2);
        query(0, "1\n");
    endtask : opc_test
    task automatic deadlock_test;
        ctl.rd(6'h24, d);
        repeat (1024) ctl.wr(6'h14, 32'h5a);
        repeat (3) @(posedge ref_clk_i);
        rdchk("stb", 6'h2c, 6'h04);
        query(2, "4\n");
        query(1, "-410,\"Query DEADLOCKED\"\n");
    endtask : deadlock_test
    task automatic clear_test;
        ctl.wr(6'h14, 32'h41);
        repeat (256) ctl.wr(6'h0c, 32'h42);
        rdchk("full input", 6'h08, 6'h01);
        ctl.rd(6'h10, d);
        chk("in pop", 32'h142, d);
        rdchk("in freed", 6'h08, 6'h03);
        ctl.clear();
        rdchk("cleared", 6'h08, 6'h02);
    endtask : clear_test
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        avail_test();
        error_test();
        opc_test();
        deadlock_test();
        clear_test();
        close_out();
    end
endmodule : tb
